/* File: verilog/fmd_pkg.sv */
// Constants, types and register map of the 300 baud FSK modem core.
// Operation
// - Modulate and demodulate FSK at 300 baud
// - Transmit one channel, receive the opposite one
// - All tones divided from one crystal clock
// - Channel select and data pick the tone
// - Rate multiplier fractions of 256, two /16
// - Eight multiplier steps per data transition
// - Seven switches scanned into sixteen sine steps
// - Zero means conducting, one means open
// - Square tone on one open-drain switch
// - Second-order DPLL with XOR phase detector
// - Output twice carrier, duty tracks phase error
// - Twelve-bit loop counters, small load bias
// - Loop centres 1080 and 1750 Hz
// - Lock detect mostly high outside range
package fmd_pkg;

    // ----------------------------------------------------------------
    // Clocking
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int XTAL_HZ = 5242880;
    localparam logic [20:0] XTAL_INC = 21'(XTAL_HZ / 20);
    localparam logic [20:0] XTAL_MOD = 21'(CLK_HZ / 20);
    localparam logic [2:0] PRE_LAST = 3'h7;
    localparam int TICK_HZ = XTAL_HZ / 8;

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    localparam logic [7:0] FRAC_LOW_BAND = 8'd98;
    localparam logic [7:0] FRAC_HIGH_BAND = 8'd165;
    localparam logic [7:0] FRAC_SHIFT = 8'd20;
    localparam logic [3:0] SHAPE_STEPS = 4'h8;
    localparam logic [6:0] CLAMP_PATTERN = 7'h0f;
    localparam int SQUARE_SW = 3;

    // ----------------------------------------------------------------
    // Receiver centres and ranges in Hz, half periods in receive ticks
    // ----------------------------------------------------------------
    localparam int LB_CENTRE = 1080;
    localparam int LB_RANGE = 398;
    localparam int HB_CENTRE = 1750;
    localparam int HB_RANGE = 335;
    localparam logic [11:0] LB_HP = 12'(TICK_HZ / (2 * LB_CENTRE));
    localparam logic [11:0] LB_HP_MIN = 12'(TICK_HZ / (2 * LB_CENTRE + LB_RANGE));
    localparam logic [11:0] LB_HP_MAX = 12'(TICK_HZ / (2 * LB_CENTRE - LB_RANGE));
    localparam logic [11:0] HB_HP = 12'(TICK_HZ / (2 * HB_CENTRE));
    localparam logic [11:0] HB_HP_MIN = 12'(TICK_HZ / (2 * HB_CENTRE + HB_RANGE));
    localparam logic [11:0] HB_HP_MAX = 12'(TICK_HZ / (2 * HB_CENTRE - HB_RANGE));

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_INT_STAT = 8'h08;
    localparam logic [7:0] REG_INT_MASK = 8'h0c;
    localparam int CTRL_SQUARE = 0;
    localparam int CTRL_RX_EN = 1;
    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam int ST_CHAN = 0;
    localparam int ST_DATA = 1;
    localparam int ST_CLAMP = 2;
    localparam int ST_LOCK = 3;
    localparam int ST_SHAPE = 4;
    localparam int ST_HP = 8;
    localparam int INT_LOCK_SET = 0;
    localparam int INT_LOCK_CLR = 1;
    localparam int INT_SHAPE_DONE = 2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } fmd_apb_req_t;

    typedef enum logic [1:0] {
        SH_HOLD = 2'b00,
        SH_RISE = 2'b01,
        SH_FALL = 2'b10
    } fmd_shape_t;

endpackage

/* File: verilog/fmd_modem.sv */
// Transmitter, receive loop and APB registers of the FSK modem core.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module fmd_modem
    import fmd_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire fmd_apb_req_t apb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic chan_sel_in,
    input wire logic tx_data_in,
    input wire logic data_clamp_in,
    input wire logic fsk_rx_in,
    input wire logic [6:0] sw_in,
    output logic [6:0] sw_out,
    output logic [6:0] sw_oe_out,
    output logic pll_out,
    output logic lock_out,
    output logic irq_out
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == REG_CTRL) || (a == REG_STATUS) ||
                  (a == REG_INT_STAT) || (a == REG_INT_MASK);
    endfunction

    function automatic logic [11:0] clamp_hp(input logic signed [14:0] v,
                                             input logic [11:0] lo,
                                             input logic [11:0] hi);
        if (v < $signed({3'h0, lo}))
            clamp_hp = lo;
        else if (v > $signed({3'h0, hi}))
            clamp_hp = hi;
        else
            clamp_hp = v[11:0];
    endfunction

    // ----------------------------------------------------------------
    // Crystal tick and receive tick
    // ----------------------------------------------------------------
    logic [20:0] acc_q;
    logic [20:0] acc_sum;
    logic xtal_tick;
    logic [2:0] pre_q;
    logic tick;

    always_comb
    begin
        acc_sum = acc_q + XTAL_INC;
        xtal_tick = (acc_sum >= XTAL_MOD);
        tick = xtal_tick && (pre_q == PRE_LAST);
    end

    // The crystal rate is synthesised exactly from the system clock.
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            acc_q <= 21'h0;
            pre_q <= 3'h0;
        end
        else
        begin
            acc_q <= xtal_tick ? acc_sum - XTAL_MOD : acc_sum;
            if (xtal_tick)
                pre_q <= pre_q + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // Rate multiplier and dividers
    // ----------------------------------------------------------------
    logic [7:0] frm_q;
    logic [8:0] frm_sum;
    logic [7:0] frac_q;
    logic [3:0] div_q;
    logic [3:0] scan_q;
    logic step;
    logic cycle;

    always_comb
    begin
        frm_sum = {1'b0, frm_q} + {1'b0, frac_q};
        step = tick && frm_sum[8] && (div_q == 4'hf);
        cycle = step && (scan_q == 4'hf);
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            frm_q <= 8'h0;
            div_q <= 4'h0;
            scan_q <= 4'h0;
        end
        else if (tick)
        begin
            frm_q <= frm_sum[7:0];
            if (frm_sum[8])
                div_q <= div_q + 4'h1;
            if (step)
                scan_q <= scan_q + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Baseband shaping
    // ----------------------------------------------------------------
    fmd_shape_t shape_q;
    logic [3:0] idx_q;
    logic data_q;
    logic shape_done;
    logic [7:0] frac_d;
    logic [11:0] shift_prod;

    always_comb
    begin
        shift_prod = 12'(FRAC_SHIFT) * {8'h0, idx_q};
        frac_d = (chan_sel_in ? FRAC_LOW_BAND : FRAC_HIGH_BAND) + shift_prod[10:3];
        shape_done = 1'b0;
        if (cycle)
        begin
            case (shape_q)
                SH_RISE: shape_done = (idx_q == SHAPE_STEPS - 4'h1);
                SH_FALL: shape_done = (idx_q == 4'h1);
                default: shape_done = 1'b0;
            endcase
        end
    end

    // A data edge walks the multiplier one step per tone cycle.
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            shape_q <= SH_HOLD;
            idx_q <= 4'h0;
            data_q <= 1'b0;
            frac_q <= FRAC_HIGH_BAND;
        end
        else
        begin
            frac_q <= frac_d;
            data_q <= tx_data_in;
            if (tx_data_in != data_q)
                shape_q <= tx_data_in ? SH_RISE : SH_FALL;
            else if (cycle)
            begin
                case (shape_q)
                    SH_RISE:
                    begin
                        if (idx_q != SHAPE_STEPS)
                            idx_q <= idx_q + 4'h1;
                        if (shape_done || (idx_q == SHAPE_STEPS))
                            shape_q <= SH_HOLD;
                    end
                    SH_FALL:
                    begin
                        if (idx_q != 4'h0)
                            idx_q <= idx_q - 4'h1;
                        if (shape_done || (idx_q == 4'h0))
                            shape_q <= SH_HOLD;
                    end
                    default: shape_q <= SH_HOLD;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Switch array
    // ----------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [6:0] sine_on;
    logic [6:0] sw_on;

    // Switch i conducts from step i+1 and is released again from step i+9.
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++)
        begin : g_sine
            assign sine_on[gi] = (scan_q > 4'(gi)) && (scan_q < 4'(gi + 9));
        end
    endgenerate

    always_comb
    begin
        sw_on = sine_on;
        if (data_clamp_in)
            sw_on = CLAMP_PATTERN;
        else if (ctrl_q[CTRL_SQUARE])
        begin
            sw_on = 7'h0;
            sw_on[SQUARE_SW] = scan_q[3];
        end
    end

    // A conducting switch pulls its pin low, shown as level 0.
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            sw_oe_out <= 7'h0;
            sw_out <= 7'h0;
        end
        else
        begin
            sw_oe_out <= sw_on;
            sw_out <= 7'h0;
        end
    end

    // ----------------------------------------------------------------
    // Receive phase locked loop
    // ----------------------------------------------------------------
    logic fsk_q;
    logic chan_q;
    logic osc_q;
    logic [11:0] hcnt_q;
    logic [11:0] len_q;
    logic [11:0] xcnt_q;
    logic [11:0] hp_q;
    logic [11:0] hp_lo;
    logic [11:0] hp_hi;
    logic [11:0] hp_mid;
    logic signed [14:0] err;
    logic rx_run;
    logic half_end;

    always_comb
    begin
        // Receive on the band opposite to transmit.
        hp_lo = chan_sel_in ? HB_HP_MIN : LB_HP_MIN;
        hp_hi = chan_sel_in ? HB_HP_MAX : LB_HP_MAX;
        hp_mid = chan_sel_in ? HB_HP : LB_HP;
        rx_run = ctrl_q[CTRL_RX_EN];
        half_end = tick && (hcnt_q <= 12'h1);
        err = $signed({3'h0, xcnt_q}) - $signed({4'h0, len_q[11:1]});
    end

    // Integral path retunes hp_q, proportional path trims this load only.
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            fsk_q <= 1'b0;
            chan_q <= 1'b0;
            osc_q <= 1'b0;
            hcnt_q <= LB_HP;
            len_q <= LB_HP;
            xcnt_q <= 12'h0;
            hp_q <= LB_HP;
        end
        else
        begin
            fsk_q <= fsk_rx_in;
            chan_q <= chan_sel_in;
            if (!rx_run || (chan_q != chan_sel_in))
            begin
                osc_q <= 1'b0;
                hcnt_q <= hp_mid;
                len_q <= hp_mid;
                xcnt_q <= 12'h0;
                hp_q <= hp_mid;
            end
            else if (half_end)
            begin
                osc_q <= ~osc_q;
                hp_q <= clamp_hp($signed({3'h0, hp_q}) - (err >>> 3), hp_lo, hp_hi);
                hcnt_q <= clamp_hp($signed({3'h0, hp_q}) - (err >>> 1), hp_lo, hp_hi);
                len_q <= clamp_hp($signed({3'h0, hp_q}) - (err >>> 1), hp_lo, hp_hi);
                xcnt_q <= 12'h0;
            end
            else if (tick)
            begin
                hcnt_q <= hcnt_q - 12'h1;
                if (fsk_q ^ osc_q)
                    xcnt_q <= xcnt_q + 12'h1;
            end
        end
    end

    logic lock_prev_q;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            pll_out <= 1'b0;
            lock_out <= 1'b0;
            lock_prev_q <= 1'b0;
        end
        else
        begin
            pll_out <= rx_run && (fsk_q ^ osc_q);
            lock_out <= rx_run && ((hp_q == hp_lo) || (hp_q == hp_hi));
            lock_prev_q <= lock_out;
        end
    end

    // ----------------------------------------------------------------
    // APB registers and interrupt
    // ----------------------------------------------------------------
    logic [2:0] int_stat_q;
    logic [2:0] int_mask_q;
    logic [2:0] events;
    logic [2:0] w1c;
    logic [31:0] rdata;
    logic wr;

    always_comb
    begin
        events = 3'h0;
        events[INT_LOCK_SET] = lock_out && !lock_prev_q;
        events[INT_LOCK_CLR] = !lock_out && lock_prev_q;
        events[INT_SHAPE_DONE] = shape_done && (tx_data_in == data_q);
        wr = apb_in.psel && apb_in.penable && pready_out && apb_in.pwrite &&
             reg_hit(apb_in.paddr);
        w1c = (wr && (apb_in.paddr == REG_INT_STAT)) ? apb_in.pwdata[2:0] : 3'h0;
        rdata = 32'h0;
        case (apb_in.paddr)
            REG_CTRL: rdata[7:0] = ctrl_q;
            REG_STATUS:
            begin
                rdata[ST_CHAN] = chan_q;
                rdata[ST_DATA] = data_q;
                rdata[ST_CLAMP] = data_clamp_in;
                rdata[ST_LOCK] = lock_out;
                rdata[ST_SHAPE +: 4] = idx_q;
                rdata[ST_HP +: 12] = hp_q;
            end
            REG_INT_STAT: rdata[2:0] = int_stat_q;
            REG_INT_MASK: rdata[2:0] = int_mask_q;
            default: rdata = 32'h0;
        endcase
    end

    // Zero-wait slave: data is latched in the setup cycle.
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end
        else
        begin
            pready_out <= apb_in.psel && !apb_in.penable;
            if (apb_in.psel && !apb_in.penable)
            begin
                prdata_out <= apb_in.pwrite ? 32'h0 : rdata;
                pslverr_out <= !reg_hit(apb_in.paddr);
            end
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            ctrl_q <= {6'h0, CTRL_RST};
            int_mask_q <= 3'h0;
        end
        else if (wr)
        begin
            if (apb_in.paddr == REG_CTRL)
                ctrl_q <= {6'h0, apb_in.pwdata[1:0]};
            if (apb_in.paddr == REG_INT_MASK)
                int_mask_q <= apb_in.pwdata[2:0];
        end
    end

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            int_stat_q <= 3'h0;
            irq_out <= 1'b0;
        end
        else
        begin
            int_stat_q <= (int_stat_q & ~w1c) | events;
            irq_out <= |(((int_stat_q & ~w1c) | events) & int_mask_q);
        end
    end

endmodule // fmd_modem

/* File: testbench/fmd_line_model.sv */
// Line-side model that feeds a limited logic FSK tone to the receive input.
`timescale 1ns/1ps
module fmd_line_model
(
    input wire logic [31:0] half_ns_in,
    output logic fsk_out
);
    // A half period of zero parks the line low.
    initial
    begin
        fsk_out = 1'b0;
        forever
        begin
            #((half_ns_in == 32'd0) ? 1000 : half_ns_in);
            if (half_ns_in != 32'd0)
                fsk_out = ~fsk_out;
            else
                fsk_out = 1'b0;
        end
    end
endmodule // fmd_line_model

/* File: testbench/fmd_modem_checker.sv */
// Concurrent checks on the ports of the FSK modem core.
`timescale 1ns/1ps
module fmd_modem_checker
    import fmd_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire fmd_apb_req_t apb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic data_clamp_in,
    input wire logic [6:0] sw_out,
    input wire logic [6:0] sw_oe_out,
    input wire logic pll_out,
    input wire logic lock_out,
    input wire logic irq_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // Legal switch sets: a run from the first switch, a run to the last, or the square pin.
    function automatic logic shape_ok(input logic [6:0] v);
        logic [6:0] n;
        n = ~v;
        return ((v & (v + 7'h01)) == 7'h00) || ((n & (n + 7'h01)) == 7'h00) || (v == 7'h08);
    endfunction

    a_reset_idle: assert property ($fell(rst_in) |-> (sw_oe_out == 7'h00) && !pll_out
        && !lock_out && !irq_out && !pready_out) else $error("outputs not idle after reset");
    a_drive_low: assert property (sw_out == 7'h00)
        else $error("switch pin driven high");
    a_sine_shape: assert property (shape_ok(sw_oe_out))
        else $error("illegal switch pattern");
    a_clamp_hold: assert property (data_clamp_in [*4] |-> sw_oe_out == 7'h0f)
        else $error("clamp pattern wrong");
    a_pready_setup: assert property (apb_in.psel && !apb_in.penable |=> pready_out)
        else $error("no ready after setup");
    a_pready_only: assert property (pready_out |-> $past(apb_in.psel && !apb_in.penable))
        else $error("ready without setup");
    a_slverr_map: assert property (pready_out |-> pslverr_out ==
        (apb_in.paddr[7:4] != 4'h0 || apb_in.paddr[1:0] != 2'h0)) else $error("error flag wrong");
    a_err_reads_zero: assert property (pready_out && pslverr_out |-> prdata_out == 32'h0)
        else $error("error read not zero");

    c_clamp: cover property (data_clamp_in [*4]);
    c_slverr: cover property (pready_out && pslverr_out);
    c_lock: cover property ($rose(lock_out));
    c_irq: cover property ($rose(irq_out));
endmodule // fmd_modem_checker

bind fmd_modem fmd_modem_checker u_checker (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .apb_in(apb_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .data_clamp_in(data_clamp_in), .sw_out(sw_out), .sw_oe_out(sw_oe_out), .pll_out(pll_out),
    .lock_out(lock_out), .irq_out(irq_out));

/* File: testbench/fmd_modem_tb_top.sv */
// Self-checking bench for the FSK modem core.
`timescale 1ns/1ps
module fmd_modem_tb_top;
    import fmd_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    fmd_apb_req_t apb = '0;
    logic chan = 1'b0;
    logic txd = 1'b0;
    logic clamp = 1'b0;
    logic fsk;
    logic [31:0] half_ns = 32'd0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [6:0] sw;
    logic [6:0] sw_oe;
    logic pll;
    logic lock;
    logic irq;
    logic pll_d = 1'b0;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int tests_run = 0;
    int pll_rises = 0;

    always #25 ref_clk_in = ~ref_clk_in;

    always @(posedge ref_clk_in)
    begin
        pll_d <= pll;
        if (pll === 1'b1 && pll_d === 1'b0)
            pll_rises <= pll_rises + 1;
    end

    fmd_modem dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .apb_in(apb), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .chan_sel_in(chan), .tx_data_in(txd),
        .data_clamp_in(clamp), .fsk_rx_in(fsk), .sw_in(7'h00), .sw_out(sw), .sw_oe_out(sw_oe),
        .pll_out(pll), .lock_out(lock), .irq_out(irq));
    fmd_line_model u_line (.half_ns_in(half_ns), .fsk_out(fsk));

    task automatic close_out();
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_up(input string what);
        check(what, 32'h0, 32'h1);
        close_out();
    endtask

    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge ref_clk_in);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge ref_clk_in);
        apb.penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge ref_clk_in);
            if (pready === 1'b1)
                break;
        end
        if (n == 16)
            give_up("ready wait");
        rd = prdata;
        er = pslverr;
        apb <= '0;
    endtask

    task automatic wait_rise(output int cyc);
        logic prev;
        prev = sw_oe[0];
        for (cyc = 1; cyc < 40000; cyc++)
        begin
            @(posedge ref_clk_in);
            if (sw_oe[0] === 1'b1 && prev === 1'b0)
                return;
            prev = sw_oe[0];
        end
        give_up("tone edge");
    endtask

    task automatic t_regs();
        bus(1'b0, REG_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h2);
        bus(1'b0, REG_INT_MASK, 32'h0);
        check("mask reset", rd, 32'h0);
        bus(1'b1, REG_STATUS, 32'hffffffff);
        bus(1'b0, REG_STATUS, 32'h0);
        check("status bits", rd[2:0], 32'h0);
        bus(1'b1, 8'h10, 32'h1);
        check("unmapped write", er, 32'h1);
        bus(1'b0, 8'h10, 32'h0);
        check("unmapped read", {rd[30:0], er}, 32'h1);
    endtask

    task automatic t_tone(input int hz);
        int c;
        wait_rise(c);
        wait_rise(c);
        check("tone period", 32'((c * hz / 200000) inside {[98:101]}), 32'h1);
    endtask

    task automatic t_shape();
        int steps;
        int p0;
        logic [3:0] idx;
        realtime t0;
        real e;
        steps = 0;
        idx = 4'h0;
        p0 = pll_rises;
        t0 = $realtime;
        txd <= 1'b1;
        for (int n = 0; n < 60000 && idx != 4'h8; n++)
        begin
            bus(1'b0, REG_STATUS, 32'h0);
            if (rd[7:4] !== idx)
            begin
                check("shape step", rd[7:4], idx + 4'h1);
                idx = rd[7:4];
                steps++;
            end
        end
        check("shape count", steps, 8);
        check("data bit", rd[1], 32'h1);
        e = ($realtime - t0) * 2.16e-6;
        check("pll rate", 32'((pll_rises - p0) >= e * 0.9 - 2.0 && (pll_rises - p0) <= e * 1.1 + 2.0),
            32'h1);
        bus(1'b0, REG_INT_STAT, 32'h0);
        check("shape event", rd[2], 32'h1);
        check("irq masked", irq, 32'h0);
        bus(1'b1, REG_INT_MASK, 32'h4);
        repeat (2) @(posedge ref_clk_in);
        check("irq raised", irq, 32'h1);
        bus(1'b1, REG_INT_STAT, 32'h4);
        repeat (2) @(posedge ref_clk_in);
        check("irq cleared", irq, 32'h0);
    endtask

    task automatic t_clamp();
        int seen8;
        int bad;
        seen8 = 0;
        bad = 0;
        clamp <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
        check("clamp switches", sw_oe, 32'h0f);
        bus(1'b0, REG_STATUS, 32'h0);
        check("clamp bit", rd[2], 32'h1);
        clamp <= 1'b0;
        bus(1'b1, REG_CTRL, 32'h3);
        repeat (4) @(posedge ref_clk_in);
        repeat (12000)
        begin
            @(posedge ref_clk_in);
            if (sw_oe === 7'h08)
                seen8 = 1;
            else if (sw_oe !== 7'h00)
                bad++;
        end
        check("square other", bad, 32'h0);
        check("square seen", seen8, 32'h1);
        bus(1'b1, REG_CTRL, 32'h2);
    endtask

    task automatic t_lock();
        int n;
        half_ns <= 32'd384600;
        for (n = 0; n < 160000 && lock !== 1'b1; n++)
            @(posedge ref_clk_in);
        if (n == 160000)
            give_up("lock wait");
        check("lock out", lock, 32'h1);
        bus(1'b0, REG_INT_STAT, 32'h0);
        check("lock event", rd[0], 32'h1);
        chan <= 1'b1;
        bus(1'b0, REG_STATUS, 32'h0);
        check("chan bit", rd[0], 32'h1);
        bus(1'b1, REG_CTRL, 32'h0);
        repeat (4) @(posedge ref_clk_in);
        check("rx off", {pll, lock}, 32'h0);
    endtask

    initial
    begin
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        half_ns <= 32'd462950;
        t_regs();
        t_tone(1650);
        t_shape();
        t_tone(1850);
        t_clamp();
        t_lock();
        close_out();
    end
endmodule // fmd_modem_tb_top
